/* File: shared/drive_safety_consts.svh */
// constants for the drive safety supervisor: thresholds, stop codes, reset values
// assumes speeds in rpm or mm/min and positions in signed encoder units
`ifndef DRIVE_SAFETY_CONSTS_SVH
`define DRIVE_SAFETY_CONSTS_SVH
`define SPINDLE_STANDSTILL_RPM    16'h000a
`define AXIS_STANDSTILL_MM_MIN    16'h0032
`define STOP_CODE_NONE            2'h0
`define STOP_CODE_SS2             2'h1
`define STOP_CODE_SS1             2'h2
`define STOP_CODE_SS0             2'h3
`define SS2_TIMER_WIDTH           16
`define FLAG_RESET                1'h0
`define ROOM_RESET                2'h0
`endif

/* File: shared/drive_safety_pkg.sv */
// types shared by the drive safety supervisor and its per-axis checker
// assumes drive_safety_consts.svh is on the include path
package drive_safety_pkg;
   typedef enum logic [1:0]
   {
      stop_none = 2'b00,
      stop_ss2  = 2'b01,
      stop_ss1  = 2'b10,
      stop_ss0  = 2'b11
   } stop_e;
   typedef logic [15:0] speed_t;
   typedef logic signed [31:0] pos_t;
endpackage : drive_safety_pkg

/* File: rtl/axis_limit_check.sv */
// per-axis speed and position comparisons of one channel
// assumes both channels feed their own measured values; purely combinational
`timescale 1ns/1ps
`include "drive_safety_consts.svh"
module axis_limit_check
(
   input  wire logic                      is_spindle,
   input  wire drive_safety_pkg::speed_t  speed_abs,
   input  wire drive_safety_pkg::speed_t  speed_limit,
   input  wire drive_safety_pkg::pos_t    position,
   input  wire drive_safety_pkg::pos_t    positive_position_limit,
   input  wire drive_safety_pkg::pos_t    negative_position_limit,
   input  wire drive_safety_pkg::speed_t  standstill_travel,
   input  wire drive_safety_pkg::speed_t  standstill_path_limit,
   output logic                           at_standstill,
   output logic                           over_speed,
   output logic                           above_positive,
   output logic                           below_negative,
   output logic                           path_exceeded
);
   import drive_safety_pkg::*;
   always_comb
   begin
      // spindle threshold in rpm, axis in mm/min
      if (is_spindle)
         at_standstill = speed_abs < `SPINDLE_STANDSTILL_RPM;
      else
         at_standstill = speed_abs < `AXIS_STANDSTILL_MM_MIN;
      // axis-specific limit, never a path speed
      over_speed     = speed_abs > speed_limit;
      above_positive = position > positive_position_limit;
      below_negative = position < negative_position_limit;
      path_exceeded  = standstill_travel > standstill_path_limit;
   end
endmodule : axis_limit_check

/* File: rtl/drive_safety_monitor.sv */
// dual-channel drive safety supervisor: torque off, standstill, limited speed,
// limited position, reference-run gating and graded stop reactions
// assumes inputs synchronous to mclk; both channels present measured values per axis
//
// Operation
// - torque-off request forces all per-axis pulse outputs of both channels inactive.
// - main channel also drops both global torque-off outputs during torque off.
// - standstill monitoring off during torque off, except cut-out channel test.
// - torque off in one channel only: other channel watches standstill position.
// - torque off drops machine control voltage latch via global output; line stays.
// - safe operating stop keeps control running; both channels watch standstill.
// - standstill means spindle below 10 rpm, axis below 50 mm/min.
// - exceeding standstill speed during safe operating stop starts stop category 1.
// - exceeding standstill path under threshold speed starts stop category 0.
// - first safety mode: guard door opening activates safe operating stop.
// - both channels compare nominal and actual values during safe operating stop.
// - limited speed watched with door open in every mode except first.
// - either channel seeing overspeed starts stop category 1.
// - speed compared per axis against own limit, never path speed.
// - limited speed becoming active while above limit stops at once.
// - speed-limit request clamps to mode speed; first mode commands stop.
// - both channels compare position against positive and negative limits; stop 1.
// - after first violation only return motion allowed; wrong way stops and blocks.
// - reference run: several unsupervised axes moving gives stop 2 to those groups.
// - door open: reference run needs start plus permissive key; closed: keys too.
// - axis traverse blocked in other modes until its reference run is done.
// - position mismatch marks axis unchecked; outside reference run, unchecked moves only with door closed.
// - stop 0 removes torque and applies brakes; restart only after power cycle.
// - stop 2 loads monitoring timers; at standstill non-spindle axes hold, spindle pulses stay on.
`timescale 1ns/1ps
`include "drive_safety_consts.svh"
module drive_safety_monitor
#(
   parameter int NUM_AXES = 4
)
(
   input  wire logic                                    mclk,
   input  wire logic                                    reset,
   // requests and operator inputs
   input  wire logic                                    torque_off_request,
   input  wire logic                                    cutout_test,
   input  wire logic                                    guard_door_open,
   input  wire logic                                    first_safety_mode,
   input  wire logic                                    speed_limit_request,
   input  wire logic                                    reference_mode,
   input  wire logic                                    program_start,
   input  wire logic                                    permissive_key,
   input  wire logic                                    direction_key,
   input  wire logic                                    limits_reconfigured,
   input  wire logic [NUM_AXES-1:0]                     is_spindle,
   input  wire logic [NUM_AXES-1:0]                     group_supervised,
   input  wire logic [NUM_AXES-1:0]                     reference_done,
   input  wire logic [NUM_AXES-1:0]                     position_mismatch,
   input  wire logic [NUM_AXES-1:0]                     moving_positive,
   input  wire logic [NUM_AXES-1:0]                     moving_negative,
   input  wire logic [NUM_AXES-1:0]                     nominal_actual_error,
   // per-axis values, main then drive channel
   input  wire drive_safety_pkg::speed_t [NUM_AXES-1:0] main_speed,
   input  wire drive_safety_pkg::speed_t [NUM_AXES-1:0] drive_speed,
   input  wire drive_safety_pkg::pos_t   [NUM_AXES-1:0] main_position,
   input  wire drive_safety_pkg::pos_t   [NUM_AXES-1:0] drive_position,
   input  wire drive_safety_pkg::speed_t [NUM_AXES-1:0] main_standstill_travel,
   input  wire drive_safety_pkg::speed_t [NUM_AXES-1:0] drive_standstill_travel,
   input  wire drive_safety_pkg::speed_t [NUM_AXES-1:0] speed_limit,
   input  wire drive_safety_pkg::pos_t   [NUM_AXES-1:0] positive_position_limit,
   input  wire drive_safety_pkg::pos_t   [NUM_AXES-1:0] negative_position_limit,
   input  wire drive_safety_pkg::speed_t [NUM_AXES-1:0] standstill_path_limit,
   input  wire logic [`SS2_TIMER_WIDTH-1:0]             ss2_timer_load,
   // outputs
   output logic [NUM_AXES-1:0]                          main_axis_pulse_off_n,
   output logic [NUM_AXES-1:0]                          drive_axis_pulse_off_n,
   output logic                                         main_global_torque_off_n,
   output logic                                         main_global_supply_off_n,
   output logic [NUM_AXES-1:0]                          brake_release,
   output logic [NUM_AXES-1:0]                          motion_enable,
   output logic                                         clamp_speed,
   output logic                                         command_stop,
   output logic                                         operating_stop_active,
   output logic                                         limited_speed_active,
   output logic [NUM_AXES-1:0]                          axis_unchecked,
   output drive_safety_pkg::stop_e                      stop_level,
   output logic                                         ss2_timeout
);
   import drive_safety_pkg::*;

   // ========
   // state
   typedef struct packed
   {
      stop_e                          stop;
      logic                           torque_off;
      logic                           latched_ss0;
      logic [NUM_AXES-1:0]            main_pulse_off_n;
      logic [NUM_AXES-1:0]            drive_pulse_off_n;
      logic                           global_off_n;
      logic [NUM_AXES-1:0]            brake_rel;
      logic [NUM_AXES-1:0]            motion_en;
      logic [NUM_AXES-1:0]            unchecked;
      logic [NUM_AXES-1:0]            pos_violated;
      logic [NUM_AXES-1:0]            pos_blocked;
      logic [NUM_AXES-1:0]            hold_axis;
      logic [`SS2_TIMER_WIDTH-1:0]    ss2_timer;
      logic                           ss2_timeout;
      logic                           clamp;
      logic                           cmd_stop;
   } state_s;

   state_s state_q;
   state_s state_d;

   // ========
   // per-axis comparisons, one checker per axis and channel
   logic [NUM_AXES-1:0] m_still, d_still, m_over, d_over;
   logic [NUM_AXES-1:0] m_hi, d_hi, m_lo, d_lo, m_path, d_path;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_AXES; gi++)
      begin : g_axis
         axis_limit_check u_main
         (
            .is_spindle              (is_spindle[gi]),
            .speed_abs               (main_speed[gi]),
            .speed_limit             (speed_limit[gi]),
            .position                (main_position[gi]),
            .positive_position_limit (positive_position_limit[gi]),
            .negative_position_limit (negative_position_limit[gi]),
            .standstill_travel       (main_standstill_travel[gi]),
            .standstill_path_limit   (standstill_path_limit[gi]),
            .at_standstill           (m_still[gi]),
            .over_speed              (m_over[gi]),
            .above_positive          (m_hi[gi]),
            .below_negative          (m_lo[gi]),
            .path_exceeded           (m_path[gi])
         );
         axis_limit_check u_drive
         (
            .is_spindle              (is_spindle[gi]),
            .speed_abs               (drive_speed[gi]),
            .speed_limit             (speed_limit[gi]),
            .position                (drive_position[gi]),
            .positive_position_limit (positive_position_limit[gi]),
            .negative_position_limit (negative_position_limit[gi]),
            .standstill_travel       (drive_standstill_travel[gi]),
            .standstill_path_limit   (standstill_path_limit[gi]),
            .at_standstill           (d_still[gi]),
            .over_speed              (d_over[gi]),
            .above_positive          (d_hi[gi]),
            .below_negative          (d_lo[gi]),
            .path_exceeded           (d_path[gi])
         );
      end
   endgenerate

   // ========
   // reactions
   logic                sos_active;
   logic                sls_active;
   logic                standstill_watch;
   logic                req_ss0, req_ss1, req_ss2;
   logic [NUM_AXES-1:0] moving;
   logic [NUM_AXES-1:0] unsup_moving;
   logic [NUM_AXES-1:0] wrong_way;
   logic [NUM_AXES-1:0] pos_hit;
   logic                ref_permit;
   stop_e               new_stop;

   always_comb
   begin
      state_d = state_q;
      moving  = moving_positive | moving_negative;

      sos_active = first_safety_mode & guard_door_open;
      sls_active = guard_door_open & ~first_safety_mode;

      // torque off silences standstill watch, unless cut-out test runs
      standstill_watch = ~state_q.torque_off | cutout_test;

      req_ss0 = 1'b0;
      req_ss1 = 1'b0;
      req_ss2 = 1'b0;

      // both channels watch standstill and nominal-actual match
      if (sos_active & standstill_watch)
      begin
         if (|(~m_still | ~d_still))
            req_ss1 = 1'b1;
         if (|((m_path | d_path) & m_still & d_still))
            req_ss0 = 1'b1;
         if (|nominal_actual_error)
            req_ss1 = 1'b1;
      end

      // one-channel torque off: the live channel sees pulses off on the other
      if (|(main_axis_pulse_off_n ^ drive_axis_pulse_off_n) &
          |((~m_still | ~d_still | m_path | d_path) &
            (main_axis_pulse_off_n ^ drive_axis_pulse_off_n)))
         req_ss0 = 1'b1;

      // overspeed from either channel; a fresh activation above limit trips at once
      if (sls_active & |(m_over | d_over))
         req_ss1 = 1'b1;

      // position limits and return-travel permission
      pos_hit   = m_hi | d_hi | m_lo | d_lo;
      wrong_way = ((m_hi | d_hi) & moving_positive) | ((m_lo | d_lo) & moving_negative);
      for (int i = 0; i < NUM_AXES; i++)
      begin
         if (pos_hit[i] & ~state_q.pos_violated[i])
         begin
            state_d.pos_violated[i] = 1'b1;
            req_ss1 = 1'b1;
         end
         else if (state_q.pos_violated[i] & wrong_way[i])
         begin
            state_d.pos_blocked[i] = 1'b1;
            req_ss1 = 1'b1;
         end
         if (limits_reconfigured & ~pos_hit[i])
         begin
            state_d.pos_violated[i] = 1'b0;
            state_d.pos_blocked[i]  = 1'b0;
         end
      end

      // reference run: more than one unsupervised axis in motion
      unsup_moving = moving & ~group_supervised & ~is_spindle;
      if (reference_mode & ($countones(unsup_moving) > 1))
      begin
         req_ss2 = 1'b1;
         state_d.hold_axis = state_q.hold_axis | ~group_supervised;
      end

      // most severe request wins; stop 0 is held until power cycle
      new_stop = state_q.stop;
      if (req_ss0 | state_q.latched_ss0)
         new_stop = stop_ss0;
      else if (req_ss1 & (state_q.stop != stop_ss0))
         new_stop = stop_ss1;
      else if (req_ss2 & (state_q.stop == stop_none))
         new_stop = stop_ss2;
      state_d.stop = new_stop;
      if (new_stop == stop_ss0)
         state_d.latched_ss0 = 1'b1;

      // stop 2 timers and standstill hand-over
      if ((new_stop == stop_ss2) & (state_q.stop != stop_ss2))
      begin
         state_d.ss2_timer   = ss2_timer_load;
         state_d.ss2_timeout = 1'b0;
      end
      else if ((state_q.stop == stop_ss2) & (new_stop == stop_ss2))
      begin
         if (&(m_still & d_still) & ~req_ss2)
         begin
            // non-spindle axes hold in operating stop, spindle pulses stay on
            state_d.hold_axis = state_q.hold_axis | ~is_spindle;
            state_d.stop      = stop_none;
         end
         else if (state_q.ss2_timer == '0)
            state_d.ss2_timeout = 1'b1;
         else
            state_d.ss2_timer = state_q.ss2_timer - 1'b1;
      end
      if (state_q.ss2_timeout & (new_stop != stop_ss0))
         state_d.stop = stop_ss1;

      // stop 1 recovers on a new request for control voltage once torque is off
      if ((new_stop == stop_ss1) & state_q.torque_off & ~req_ss1 & ~req_ss2 & ~torque_off_request &
          (&(m_still & d_still)))
      begin
         state_d.stop        = stop_none;
         state_d.ss2_timeout = 1'b0;
      end
      if (~guard_door_open)
         state_d.hold_axis = '0;

      state_d.torque_off = torque_off_request | (new_stop == stop_ss0) |
                           ((new_stop == stop_ss1) & (&(m_still & d_still)));

      // pulses off in both channels; spindles held after stop 2 also go off
      state_d.main_pulse_off_n  = ~({NUM_AXES{state_d.torque_off}} | (state_d.hold_axis & is_spindle));
      state_d.drive_pulse_off_n = state_d.main_pulse_off_n;
      // global output also drops the control-voltage latch
      state_d.global_off_n = ~state_d.torque_off;
      state_d.brake_rel    = (new_stop == stop_ss0) ? '0 : state_d.main_pulse_off_n;

      // speed clamp request; first mode means stop
      state_d.clamp    = speed_limit_request & ~first_safety_mode;
      state_d.cmd_stop = (speed_limit_request & first_safety_mode) | (new_stop != stop_none);

      // checked state and motion permission
      state_d.unchecked = (state_q.unchecked | position_mismatch) & ~(reference_done & ~position_mismatch);
      ref_permit = guard_door_open ? (program_start & permissive_key)
                                   : (program_start | direction_key);
      if (reference_mode)
         state_d.motion_en = {NUM_AXES{ref_permit & ~state_d.torque_off}};
      else
         state_d.motion_en = reference_done & ~(state_d.unchecked & {NUM_AXES{guard_door_open}})
                           & ~state_d.pos_blocked & ~state_d.hold_axis & ~{NUM_AXES{state_d.torque_off}};
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         state_q            <= '0;
         state_q.torque_off <= 1'b1;
      end
      else
         state_q <= state_d;
   end

   // ========
   // outputs
   assign main_axis_pulse_off_n    = state_q.main_pulse_off_n;
   assign drive_axis_pulse_off_n   = state_q.drive_pulse_off_n;
   assign main_global_torque_off_n = state_q.global_off_n;
   assign main_global_supply_off_n = state_q.global_off_n;
   assign brake_release            = state_q.brake_rel;
   assign motion_enable            = state_q.motion_en;
   assign clamp_speed              = state_q.clamp;
   assign command_stop             = state_q.cmd_stop;
   assign operating_stop_active    = sos_active;
   assign limited_speed_active     = sls_active;
   assign axis_unchecked           = state_q.unchecked;
   assign stop_level               = state_q.stop;
   assign ss2_timeout              = state_q.ss2_timeout;
endmodule : drive_safety_monitor

/* File: bench/power_stage_model.sv */
// behavioural inverter stage: turns commanded speed into measured speed
// assumes pulses count as on only when both channels release them
`timescale 1ns/1ps
module power_stage_model
#(
   parameter int N = 2
)
(
   input  wire logic                              mclk,
   input  wire logic                              reset,
   input  wire logic [N-1:0]                      pulse_on,
   input  wire drive_safety_pkg::speed_t [N-1:0]  cmd_speed,
   output drive_safety_pkg::speed_t [N-1:0]       speed
);
   import drive_safety_pkg::*;
   // without pulses the motor coasts; halving is a crude stand-in for friction
   always_ff @(posedge mclk)
   begin
      for (int i = 0; i < N; i++)
         speed[i] <= reset ? '0 : pulse_on[i] ? cmd_speed[i] : speed[i] >> 1;
   end
endmodule : power_stage_model

/* File: bench/drive_safety_chk.sv */
// port-level assertions for the drive safety supervisor
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ps
module drive_safety_chk
#(
   parameter int NUM_AXES = 4
)
(
   input wire logic                    mclk,
   input wire logic                    reset,
   input wire logic                    torque_off_request,
   input wire logic                    guard_door_open,
   input wire logic                    first_safety_mode,
   input wire logic                    reference_mode,
   input wire logic [NUM_AXES-1:0]     group_supervised,
   input wire logic [NUM_AXES-1:0]     is_spindle,
   input wire logic [NUM_AXES-1:0]     moving_positive,
   input wire logic [NUM_AXES-1:0]     moving_negative,
   input wire logic [NUM_AXES-1:0]     main_axis_pulse_off_n,
   input wire logic [NUM_AXES-1:0]     drive_axis_pulse_off_n,
   input wire logic                    main_global_torque_off_n,
   input wire logic                    main_global_supply_off_n,
   input wire logic [NUM_AXES-1:0]     brake_release,
   input wire logic                    operating_stop_active,
   input wire logic                    limited_speed_active,
   input wire drive_safety_pkg::stop_e stop_level
);
   import drive_safety_pkg::*;
   // ========
   // sequences and properties
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence pulses_gone;
      main_axis_pulse_off_n == '0 && drive_axis_pulse_off_n == '0;
   endsequence
   sequence globals_gone;
      !main_global_torque_off_n && !main_global_supply_off_n;
   endsequence
   sequence ss0_held;
      (stop_level == stop_ss0) [*2];
   endsequence
   sequence ref_crowd;
      reference_mode && group_supervised == '0 && $countones((moving_positive | moving_negative) & ~is_spindle) > 1;
   endsequence
   torque_off_a: assert property (torque_off_request |=> pulses_gone)
      else $error("pulse outputs on after torque-off request");
   global_off_a: assert property (torque_off_request |=> globals_gone)
      else $error("global torque-off outputs on after request");
   ss0_brakes_a: assert property (ss0_held |-> globals_gone ##0 (brake_release == '0))
      else $error("stop 0 left torque or brakes released");
   ss0_latch_a: assert property ($past(stop_level) == stop_ss0 |-> stop_level == stop_ss0)
      else $error("stop 0 cleared without power cycle");
   ss1_keep_a: assert property (stop_level == stop_ss1 |=> stop_level != stop_ss2)
      else $error("stop 1 demoted to stop 2");
   sos_door_a: assert property (first_safety_mode && guard_door_open |-> operating_stop_active)
      else $error("door open in first mode without operating stop");
   sls_door_a: assert property (guard_door_open && !first_safety_mode |-> limited_speed_active)
      else $error("door open without limited speed watch");
   ref_multi_a: assert property (ref_crowd |=> stop_level != stop_none)
      else $error("several axes moved in reference run without stop");
endmodule : drive_safety_chk
bind drive_safety_monitor drive_safety_chk #(.NUM_AXES(NUM_AXES)) chk
(
   .mclk, .reset, .torque_off_request, .guard_door_open, .first_safety_mode, .reference_mode,
   .group_supervised, .is_spindle, .moving_positive, .moving_negative, .main_axis_pulse_off_n,
   .drive_axis_pulse_off_n, .main_global_torque_off_n, .main_global_supply_off_n,
   .brake_release, .operating_stop_active, .limited_speed_active, .stop_level
);

/* File: bench/drive_safety_monitor_bench.sv */
// self-checking bench for the drive safety supervisor
// assumes the package and constants header are compiled first
`timescale 1ns/1ps
`include "drive_safety_consts.svh"
module drive_safety_monitor_bench;
   import drive_safety_pkg::*;
   localparam int N = 2;
   logic mclk = 1'h0, reset = 1'h1, torque_off_request, cutout_test, guard_door_open, first_safety_mode;
   logic speed_limit_request, reference_mode, program_start, permissive_key, direction_key;
   logic limits_reconfigured, main_global_torque_off_n, main_global_supply_off_n, ss2_timeout;
   logic clamp_speed, command_stop, operating_stop_active, limited_speed_active;
   logic [N-1:0] is_spindle, group_supervised, reference_done, position_mismatch, moving_positive;
   logic [N-1:0] moving_negative, nominal_actual_error, main_axis_pulse_off_n, drive_axis_pulse_off_n;
   logic [N-1:0] brake_release, motion_enable, axis_unchecked;
   speed_t [N-1:0] cmd, main_speed, main_standstill_travel, drive_standstill_travel;
   speed_t [N-1:0] speed_limit, standstill_path_limit;
   pos_t [N-1:0] main_position, drive_position, positive_position_limit, negative_position_limit;
   logic [15:0] ss2_timer_load;
   logic [31:0] r;
   stop_e stop_level;
   int fails = 0, n_checks = 0, seed = 99555;
   always #20 mclk = ~mclk;
   power_stage_model #(.N(N)) stage (.mclk, .reset, .cmd_speed(cmd), .speed(main_speed),
      .pulse_on(main_axis_pulse_off_n & drive_axis_pulse_off_n));
   drive_safety_monitor #(.NUM_AXES(N)) DUT (.mclk, .reset, .torque_off_request, .cutout_test,
      .guard_door_open, .first_safety_mode, .speed_limit_request, .reference_mode, .program_start,
      .permissive_key, .direction_key, .limits_reconfigured, .is_spindle, .group_supervised,
      .reference_done, .position_mismatch, .moving_positive, .moving_negative, .nominal_actual_error,
      .main_speed, .drive_speed(main_speed), .main_position, .drive_position, .main_standstill_travel,
      .drive_standstill_travel, .speed_limit, .positive_position_limit, .negative_position_limit,
      .standstill_path_limit, .ss2_timer_load, .main_axis_pulse_off_n, .drive_axis_pulse_off_n,
      .main_global_torque_off_n, .main_global_supply_off_n, .brake_release, .motion_enable,
      .clamp_speed, .command_stop, .operating_stop_active, .limited_speed_active, .axis_unchecked,
      .stop_level, .ss2_timeout);
   // ========
   // helpers
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   function automatic stop_e sos_expect(input logic sp, input speed_t v);
      return (v < (sp ? `SPINDLE_STANDSTILL_RPM : `AXIS_STANDSTILL_MM_MIN)) ? stop_none : stop_ss1;
   endfunction : sos_expect
   // reset each scenario so earlier stops cannot mask later ones
   task automatic restart;
      {torque_off_request, cutout_test, guard_door_open, first_safety_mode, speed_limit_request} = '0;
      {reference_mode, program_start, permissive_key, direction_key, limits_reconfigured} = '0;
      {is_spindle, moving_positive, moving_negative, position_mismatch, nominal_actual_error} = '0;
      {group_supervised, reference_done} = '1;
      {cmd, main_standstill_travel, drive_standstill_travel, main_position, drive_position} = '0;
      speed_limit = {N{16'h0100}};
      standstill_path_limit = {N{16'h0040}};
      positive_position_limit = {N{32'h00001000}};
      negative_position_limit = {N{32'hfffff000}};
      ss2_timer_load = 16'h0100;
      reset = 1'h1;
      tick(5);
      reset = 1'h0;
      tick(3);
   endtask : restart
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (100000) @(posedge mclk);
      fails++;
      final_report();
   end
   // ========
   // scenarios
   initial
   begin
      restart();
      repeat (300)
      begin
         r = $random(seed);
         {torque_off_request, cutout_test, guard_door_open, first_safety_mode, speed_limit_request,
          reference_mode, program_start, permissive_key, direction_key, limits_reconfigured} = r[9:0];
         {group_supervised, reference_done, position_mismatch, moving_positive, moving_negative,
          nominal_actual_error, is_spindle} = r[23:10];
         r = $random(seed);
         cmd = r & 32'h007f007f;
         drive_standstill_travel = {8'h00, r[7:0], 8'h00, r[15:8]};
         tick(1);
      end
      restart();
      torque_off_request = 1'h1;
      tick(1);
      chk("pulses", '0, {main_axis_pulse_off_n, drive_axis_pulse_off_n});
      chk("globals", '0, {main_global_torque_off_n, main_global_supply_off_n});
      for (int k = 0; k < 4; k++)
      begin
         restart();
         {first_safety_mode, guard_door_open} = 2'h3;
         is_spindle = {N{k[1]}};
         cmd[0] = (k[1] ? `SPINDLE_STANDSTILL_RPM : `AXIS_STANDSTILL_MM_MIN) - 16'(!k[0]);
         tick(2);
         chk("standstill stop", sos_expect(k[1], cmd[0]), stop_level);
      end
      restart();
      {first_safety_mode, guard_door_open} = 2'h3;
      cmd[0] = 16'h0040;
      main_standstill_travel[1] = 16'h0041;
      drive_standstill_travel[1] = 16'h0041;
      tick(2);
      chk("path stop", stop_ss0, stop_level);
      chk("brakes", '0, {brake_release, main_global_torque_off_n});
      {guard_door_open, cmd} = '0;
      tick(5);
      chk("stop 0 held", stop_ss0, stop_level);
      restart();
      cmd[1] = 16'h0101;
      speed_limit_request = 1'h1;
      tick(2);
      chk("door closed", stop_none, stop_level);
      chk("clamp", 1'h1, clamp_speed);
      guard_door_open = 1'h1;
      tick(1);
      chk("late limit", stop_ss1, stop_level);
      restart();
      main_position[0] = 32'h00001001;
      drive_position[0] = 32'h00001001;
      moving_positive[0] = 1'h1;
      tick(1);
      chk("position stop", stop_ss1, stop_level);
      for (int g = 0; g < 2; g++)
      begin
         restart();
         reference_mode = 1'h1;
         group_supervised = {N{g[0]}};
         moving_positive = '1;
         tick(1);
         chk("reference stop", g ? stop_none : stop_ss2, stop_level);
      end
      final_report();
   end
endmodule : drive_safety_monitor_bench
